/* File: core/power_hold_pkg.sv */
// Operation
// - any of three wake inputs starts power-up
// - powered while power key held high
// - supply hold keeps power after key release
// - charger, handsfree wake on rising edge
package power_hold_pkg;

    // core clock rate and timing
    localparam int unsigned CLK_HZ        = 10_000_000;  // core clock, 10 mhz
    localparam int unsigned HOLD_WINDOW_MS = 1200;       // hold window after edge wake
    localparam int unsigned HOLD_WINDOW_CYCLES =
        (HOLD_WINDOW_MS * (CLK_HZ / 1000));             // longest time, rounded down
    localparam int unsigned WIN_W         = 24;          // window counter width
    localparam logic [WIN_W-1:0] WIN_ZERO = 24'h000000;  // counter reset value
    localparam logic [WIN_W-1:0] WIN_ONE  = 24'h000001;  // counter step

    // power state machine
    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,  // device powered down
        ST_WINDOW = 2'b01,  // edge wake, waiting for host hold
        ST_ON     = 2'b10   // powered by key or hold
    } power_state_t;

    // wake inputs travel together
    typedef struct packed {
        logic power_key;    // power key input
        logic handsfree;    // handsfree wake input
        logic charger;      // charger present input
    } wake_inputs_t;

    // which sources caused the last start
    typedef struct packed {
        logic power_key;    // started by key
        logic handsfree;    // started by handsfree
        logic charger;      // started by charger
    } wake_cause_t;

endpackage : power_hold_pkg

/* File: core/wake_edge_detect.sv */
// rising edge / level detection of the two edge-type wake inputs
module wake_edge_detect
    import power_hold_pkg::*;
#(
    parameter bit HF_LEVEL = 1'b0  // build option: handsfree is level-sensitive
) (
    input  wire logic         core_clk_i,  // core clock
    input  wire logic         reset_i,     // sync reset, active high
    input  wire wake_inputs_t wake_i,      // raw wake inputs
    output logic              hf_start_o,  // handsfree start request
    output logic              chg_start_o  // charger start request
);
    logic hf_prev;   // last handsfree level
    logic chg_prev;  // last charger level

    // remember previous levels
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hf_prev  <= 1'b0;
            chg_prev <= 1'b0;
        end else begin
            hf_prev  <= wake_i.handsfree;
            chg_prev <= wake_i.charger;
        end
    end

    // edge or level selection
    always_comb begin
        chg_start_o = wake_i.charger & ~chg_prev;
        hf_start_o  = HF_LEVEL ? wake_i.handsfree
                               : (wake_i.handsfree & ~hf_prev);
    end

    // a held-high charger gives only one request
    a_chg_edge_once: assert property (@(posedge core_clk_i) disable iff (reset_i)
        chg_start_o |=> !chg_start_o)
        else $error("charger start request lasted two cycles");

endmodule : wake_edge_detect

/* File: core/power_up_hold_sequencer.sv */
// power-up and power-hold sequencer
//
// three states: off, window and on.
// the power key starts the device straight into the on state, and the
// device stays there while the key is high, whatever the hold does.
// a rising edge on the charger or handsfree wake opens a hold window:
// the device is powered but waits for the host to raise supply hold.
// hold or key seen inside the window moves the device to on.
// if neither arrives before the window count runs out, it powers down.
// in on, power stays while key or hold is high; with both low the device
// drops power on the next edge, so hold must be kept up continuously.
// wake edges that arrive while already powered are ignored.
// hold alone never starts the device from off.
// the handsfree wake may be built level-sensitive, in which case a
// handsfree input held high re-opens the window after each expiry.
//
module power_up_hold_sequencer
    import power_hold_pkg::*;
#(
    parameter bit                   HF_LEVEL     = 1'b0,              // handsfree level option
    parameter logic [WIN_W-1:0]     WINDOW_COUNT = WIN_W'(HOLD_WINDOW_CYCLES) // hold window
) (
    input  wire logic               core_clk_i,           // core clock
    input  wire logic               reset_i,              // sync reset, active high
    input  wire power_hold_pkg::wake_inputs_t wake_i,      // wake inputs
    input  wire logic               supply_hold_input_i,  // host supply hold
    output logic                    power_enable_o,       // device powered
    output logic                    window_active_o,      // waiting for host hold
    output power_hold_pkg::wake_cause_t cause_o           // cause of last start
);
    import power_hold_pkg::*;

    power_state_t     state;        // current state
    power_state_t     next_state;   // next state
    logic [WIN_W-1:0] win_count;    // cycles spent in window
    logic             hf_start;     // handsfree start request
    logic             chg_start;    // charger start request
    logic             win_expired;  // window ran out

    // edge detection of charger and handsfree
    wake_edge_detect #(
        .HF_LEVEL (HF_LEVEL)
    ) u_edge (
        .core_clk_i  (core_clk_i),
        .reset_i     (reset_i),
        .wake_i      (wake_i),
        .hf_start_o  (hf_start),
        .chg_start_o (chg_start)
    );

    // any edge-type wake request this cycle
    function automatic logic edge_wake(input logic hf, input logic chg);
        return hf | chg;
    endfunction : edge_wake

    // key or hold keeps the device powered
    function automatic logic keep_alive(input logic key, input logic hold);
        return key | hold;
    endfunction : keep_alive

    // last window cycle reached; the window thus lasts WINDOW_COUNT cycles
    // counter starts at zero on entry, so compare against count minus one
    assign win_expired = (win_count >= WINDOW_COUNT - WIN_ONE);

    // next state decision
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                // key starts straight into on; hold alone is refused here
                if (wake_i.power_key) begin
                    next_state = ST_ON;
                end else if (edge_wake(hf_start, chg_start)) begin
                    // edge wake opens the hold window
                    next_state = ST_WINDOW;
                end
            end
            ST_WINDOW: begin
                // host hold or key ends the window
                if (keep_alive(wake_i.power_key, supply_hold_input_i)) begin
                    next_state = ST_ON;
                end else if (win_expired) begin
                    // nobody kept the device alive in time
                    next_state = ST_OFF;
                end
            end
            ST_ON: begin
                // key keeps power regardless of hold
                if (!keep_alive(wake_i.power_key, supply_hold_input_i)) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                next_state = ST_OFF;  // illegal code recovers to off
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // window counter, cleared on every entry
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            win_count <= WIN_ZERO;
        end else if (state == ST_WINDOW) begin
            win_count <= win_count + WIN_ONE;
        end else begin
            win_count <= WIN_ZERO;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            power_enable_o  <= 1'b0;
            window_active_o <= 1'b0;
        end else begin
            power_enable_o  <= (next_state != ST_OFF);
            window_active_o <= (next_state == ST_WINDOW);
        end
    end

    // cause capture at each start from off
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cause_o <= '0;
        end else if (state == ST_OFF && next_state != ST_OFF) begin
            cause_o.power_key <= wake_i.power_key;
            cause_o.handsfree <= hf_start;
            cause_o.charger   <= chg_start;
        end
    end

    // key high always yields power next cycle
    a_key_keeps_on: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wake_i.power_key |=> power_enable_o)
        else $error("power dropped while key held");

    // any edge wake request from off starts power
    a_wake_starts: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_OFF && edge_wake(hf_start, chg_start)) |=> power_enable_o)
        else $error("wake request did not start power");

    // hold keeps power once on
    a_hold_keeps_on: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_ON && supply_hold_input_i) |=> power_enable_o)
        else $error("power dropped while hold asserted");

    // window ends with power down when unheld
    a_window_expiry: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_WINDOW && win_expired && !wake_i.power_key
         && !supply_hold_input_i) |=> !power_enable_o && state == ST_OFF)
        else $error("window expiry did not power down");

    // window never outlasts its count
    a_window_bound: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state == ST_WINDOW |-> win_count < WINDOW_COUNT)
        else $error("window counter exceeded limit");

    // power drops only when key and hold were both low
    a_off_cause: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $fell(power_enable_o)
        |-> $past(!wake_i.power_key && !supply_hold_input_i))
        else $error("power removed without cause");

    // hold alone does not start the device
    a_hold_refused_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_OFF && !wake_i.power_key && !edge_wake(hf_start, chg_start))
        |=> !power_enable_o)
        else $error("device started without a wake request");

    // key inside the window moves to on
    a_key_leaves_window: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_WINDOW && wake_i.power_key)
        |=> (state == ST_ON && !window_active_o))
        else $error("key did not end the window");

    // hold inside the window moves to on
    a_hold_ends_window: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_WINDOW && supply_hold_input_i)
        |=> (state == ST_ON && power_enable_o))
        else $error("hold did not end the window");

    // hold keeps power after key release
    a_hold_after_key: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_ON && !wake_i.power_key && supply_hold_input_i)
        |=> (state == ST_ON))
        else $error("device left on state while hold asserted");

    // edge wake from off opens the window
    a_edge_opens_window: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_OFF && !wake_i.power_key && edge_wake(hf_start, chg_start))
        |=> (window_active_o && state == ST_WINDOW))
        else $error("edge wake did not open the window");

    // wake edges while on leave the cause alone
    a_edge_ignored_on: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_ON && edge_wake(hf_start, chg_start))
        |=> $stable(cause_o))
        else $error("cause changed while already on");

    // start cause records the edge requests
    a_cause_recorded: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == ST_OFF && next_state != ST_OFF)
        |=> (cause_o.charger == $past(chg_start)
             && cause_o.handsfree == $past(hf_start)))
        else $error("start cause not recorded");

    // counter rests at zero outside the window
    a_count_cleared: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state != ST_WINDOW) |=> (win_count == WIN_ZERO))
        else $error("window counter not cleared");

    // window flag only while powered
    a_window_powered: assert property (@(posedge core_clk_i) disable iff (reset_i)
        window_active_o |-> power_enable_o)
        else $error("window flag without power");

endmodule : power_up_hold_sequencer

/* File: bench/host_hold_model.sv */
// host side: drives the supply hold input of the sequencer
module host_hold_model (
    input  wire logic       core_clk_i,      // core clock
    input  wire logic       window_active_i, // device waits for hold
    input  wire logic [1:0] mode_i,          // 0 idle, 1 answer window, 2 hold
    input  wire logic [7:0] delay_i,         // answer delay in cycles
    output logic            supply_hold_o    // supply hold to device
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;                             // window cycles seen
    initial supply_hold_o = 1'b0;
    // host changes hold just after the falling edge, never near sampling
    always begin
        @(negedge core_clk_i);
        #1;
        if (mode_i == 2'h0) begin
            supply_hold_o = 1'b0;            // released
            cnt = 0;
        end else if (mode_i == 2'h2) begin
            supply_hold_o = 1'b1;
        end else if (window_active_i) begin
            cnt++;
            if (cnt > delay_i) supply_hold_o = 1'b1;
        end
    end
endmodule : host_hold_model

/* File: bench/testbench.sv */
// self-checking bench for the power-up hold sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import power_hold_pkg::*;
    localparam logic [WIN_W-1:0] win_len = 24'h000014; // shortened window
    logic         core_clk_i = 1'b0;   // core clock
    logic         reset_i = 1'b1;      // sync reset
    logic         hold, pwr, win;      // hold in, outputs
    wake_inputs_t wake = 3'h0;         // wake inputs
    wake_cause_t  cause;               // start cause
    logic [1:0]   mode = 2'h0;         // host behaviour
    logic [7:0]   dly = 8'h00;         // host answer delay
    int bad_count = 0, comparisons = 0, cyc = 0, st = 0, cnt = 0;
    logic [2:0]   ecause = 3'h0;       // expected cause
    logic         ph = 1'b0, pc = 1'b0; // previous edge levels
    power_up_hold_sequencer #(.HF_LEVEL(1'b0), .WINDOW_COUNT(win_len)) uut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .wake_i(wake),
        .supply_hold_input_i(hold), .power_enable_o(pwr),
        .window_active_o(win), .cause_o(cause));
    host_hold_model host (.core_clk_i(core_clk_i), .window_active_i(win),
        .mode_i(mode), .delay_i(dly), .supply_hold_o(hold));
    // 10 mhz clock
    initial forever #50 core_clk_i = ~core_clk_i;
    // reference model; st: 0 off, 1 window, 2 on
    always @(posedge core_clk_i) begin : ref_model
        logic e_h, e_c;
        e_h = wake.handsfree & ~ph;
        e_c = wake.charger & ~pc;
        ph = wake.handsfree;
        pc = wake.charger;
        if (reset_i) begin
            st = 0; ph = 1'b0; pc = 1'b0; ecause = 3'h0;
        end else if (st == 0 && (wake.power_key | e_h | e_c)) begin
            ecause = {wake.power_key, e_h, e_c};
            st = wake.power_key ? 2 : 1;
            cnt = 1;
        end else if (st == 1 && (wake.power_key | hold)) st = 2;
        else if (st == 1) begin
            if (cnt == win_len) st = 0;
            cnt++;
        end else if (st == 2 && !wake.power_key && !hold) st = 0;
    end
    task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // compare every cycle, cut a hang short
    always @(negedge core_clk_i) begin
        cyc++;
        if (cyc > 4000) begin
            bad_count++;
            end_sim();
        end else if (!reset_i) begin
            chk("power", {2'h0, st != 0}, {2'h0, pwr});
            chk("window", {2'h0, st == 1}, {2'h0, win});
            chk("cause", ecause, cause);
        end
    end
    task automatic run(input logic [2:0] w, input int n);
        wake = wake_inputs_t'(w);
        repeat (n) @(negedge core_clk_i);
    endtask : run
    initial begin
        void'($urandom(32'hd101));
        repeat (4) @(negedge core_clk_i);
        reset_i = 1'b0;
        run(3'h4, 6);
        run(3'h0, 4);
        mode = 2'h2;
        run(3'h0, 5);
        run(3'h4, 3);
        run(3'h0, 8);
        mode = 2'h0;
        run(3'h0, 4);
        for (int i = 0; i < 4; i++) begin
            mode = 2'h1;
            dly = 8'($urandom_range(16));
            run(i[0] ? 3'h2 : 3'h1, 26);
            mode = 2'h0;
            run(3'h0, 3);
        end
        run(3'h2, 26);
        run(3'h0, 2);
        run(3'h1, 26);
        repeat (60) begin
            mode = 2'($urandom_range(2));
            dly = 8'($urandom_range(16));
            run(3'($urandom_range(7)), $urandom_range(1, 8));
        end
        end_sim();
    end
endmodule : testbench
